/* rtl/atf_defs.vh */
// What this block does
// - Non-digit in integer or fraction flags error
// - Exponent must start E+ or E-
// - Second exponent part flags error
// - Infinite result flags error
// - Empty text flags error
// - No terminator within 25 characters: error
// - Zero flag set only for zero result
// - Write 32-bit single value to destination
// - Only first six significant digits count
// - Notation detected automatically, no format input
// - Accept decimal and scientific notation
`ifndef ATF_DEFS_VH
`define ATF_DEFS_VH
`define ATF_CH_ZERO 8'h30
`define ATF_CH_NINE 8'h39
`define ATF_CH_EXP 8'h45
`define ATF_CH_PLUS 8'h2b
`define ATF_CH_MINUS 8'h2d
`define ATF_CH_DOT 8'h2e
`define ATF_CH_NUL 8'h00
`define ATF_MAX_CHARS 5'h19
`define ATF_MAX_DIGITS 3'h6
`define ATF_EXP_CAP 7'h63
`define ATF_FLT_BIAS 12'h07f
`define ATF_FLT_INF 12'h0ff
`define ATF_BE_INIT 12'h013
`define ATF_MANT_SHIFT 12
`define ATF_FRAC_HI 30
`define ATF_FRAC_LO 8
`endif

/* rtl/atf_convert.v */
`timescale 1ns/1ps
`include "atf_defs.vh"
module atf_convert (
  input wire ref_clk,
  input wire rst,
  input wire ascii_to_float_convert,
  input wire [15:0] src_addr,
  input wire [15:0] dst_addr,
  input wire [15:0] mem_rdata,
  output reg [15:0] mem_addr_ff,
  output reg mem_rd_ff,
  output reg mem_wr_ff,
  output reg [15:0] mem_wdata_ff,
  output reg busy_ff,
  output reg done_ff,
  output reg conversion_error_flag_ff,
  output reg zero_result_flag_ff
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_RD = 4'h1;
  localparam [3:0] S_WAIT = 4'h2;
  localparam [3:0] S_HB = 4'h3;
  localparam [3:0] S_LB = 4'h4;
  localparam [3:0] S_NORM = 4'h5;
  localparam [3:0] S_SCALE = 4'h6;
  localparam [3:0] S_PACK = 4'h7;
  localparam [3:0] S_WR_LO = 4'h8;
  localparam [3:0] S_WR_HI = 4'h9;
  localparam [3:0] S_FIN = 4'ha;

  reg [3:0] st_ff;
  reg [4:0] pos_ff;
  reg [15:0] word_ff;
  reg [15:0] dst_ff;
  reg neg_ff;
  reg dot_ff;
  reg exp_seen_ff;
  reg exp_pend_ff;
  reg eneg_ff;
  reg [6:0] eval_ff;
  reg [19:0] mant_ff;
  reg [2:0] ndig_ff;
  reg signed [7:0] dadj_ff;
  reg err_ff;
  reg [31:0] m_ff;
  reg signed [11:0] be_ff;
  reg signed [8:0] e10_ff;
  reg [31:0] res_ff;

  // ----------------------------------------------------------------
  // Character decode
  // ----------------------------------------------------------------
  wire [7:0] chr = (st_ff == S_HB) ? mem_rdata[15:8] : word_ff[7:0];
  wire is_digit = (chr >= `ATF_CH_ZERO) && (chr <= `ATF_CH_NINE);
  wire [3:0] dval = chr[3:0];
  wire is_sign = (chr == `ATF_CH_PLUS) || (chr == `ATF_CH_MINUS);
  wire last_char = (pos_ff == `ATF_MAX_CHARS - 5'h1);

  // Scaling arithmetic
  wire [35:0] mul10 = {4'h0, m_ff} * 36'h00000000a;
  wire [35:0] div10 = {m_ff, 4'h0} / 36'h00000000a;
  wire signed [7:0] eval_s = {1'b0, eval_ff};
  wire signed [8:0] e10_sum = {dadj_ff[7], dadj_ff} +
    (eneg_ff ? -{eval_s[7], eval_s} : {eval_s[7], eval_s});
  wire signed [11:0] biased = be_ff + `ATF_FLT_BIAS;

  function [6:0] exp_acc;
    input [6:0] cur;
    input [3:0] d;
    reg [10:0] t;
    begin
      t = {4'h0, cur} * 11'h00a + {7'h00, d};
      exp_acc = (t > {4'h0, `ATF_EXP_CAP}) ? `ATF_EXP_CAP : t[6:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= S_IDLE;
      pos_ff <= 5'h00;
      word_ff <= 16'h0000;
      dst_ff <= 16'h0000;
      neg_ff <= 1'b0;
      dot_ff <= 1'b0;
      exp_seen_ff <= 1'b0;
      exp_pend_ff <= 1'b0;
      eneg_ff <= 1'b0;
      eval_ff <= 7'h00;
      mant_ff <= 20'h00000;
      ndig_ff <= 3'h0;
      dadj_ff <= 8'sh00;
      err_ff <= 1'b0;
      m_ff <= 32'h00000000;
      be_ff <= 12'sh000;
      e10_ff <= 9'sh000;
      res_ff <= 32'h00000000;
      mem_addr_ff <= 16'h0000;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_wdata_ff <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      conversion_error_flag_ff <= 1'b0;
      zero_result_flag_ff <= 1'b0;
    end else begin
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      done_ff <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (ascii_to_float_convert) begin
            // Fresh parse state; no format input needed
            mem_addr_ff <= src_addr;
            dst_ff <= dst_addr;
            pos_ff <= 5'h00;
            neg_ff <= 1'b0;
            dot_ff <= 1'b0;
            exp_seen_ff <= 1'b0;
            exp_pend_ff <= 1'b0;
            eneg_ff <= 1'b0;
            eval_ff <= 7'h00;
            mant_ff <= 20'h00000;
            ndig_ff <= 3'h0;
            dadj_ff <= 8'sh00;
            err_ff <= 1'b0;
            res_ff <= 32'h00000000;
            busy_ff <= 1'b1;
            st_ff <= S_RD;
          end
        end
        S_RD: begin
          mem_rd_ff <= 1'b1;
          st_ff <= S_WAIT;
        end
        S_WAIT: begin
          st_ff <= S_HB;
        end
        S_HB, S_LB: begin
          if (st_ff == S_HB) begin
            word_ff <= mem_rdata;
          end
          pos_ff <= pos_ff + 5'h01;
          if (chr == `ATF_CH_NUL) begin
            if (pos_ff == 5'h00 || exp_pend_ff) begin
              err_ff <= 1'b1;
            end
            st_ff <= S_NORM;
          end else begin
            if (last_char) begin
              err_ff <= 1'b1;
              st_ff <= S_NORM;
            end else if (st_ff == S_HB) begin
              st_ff <= S_LB;
            end else begin
              mem_addr_ff <= mem_addr_ff + 16'h0001;
              st_ff <= S_RD;
            end
            if (exp_pend_ff) begin
              exp_pend_ff <= 1'b0;
              if (is_sign) begin
                eneg_ff <= (chr == `ATF_CH_MINUS);
              end else begin
                err_ff <= 1'b1;
              end
            end else if (chr == `ATF_CH_EXP) begin
              // Scientific form recognised here
              if (exp_seen_ff) begin
                err_ff <= 1'b1;
              end
              exp_seen_ff <= 1'b1;
              exp_pend_ff <= 1'b1;
            end else if (is_digit && exp_seen_ff) begin
              eval_ff <= exp_acc(eval_ff, dval);
            end else if (is_digit) begin
              if (ndig_ff < `ATF_MAX_DIGITS) begin
                if (dval != 4'h0 || ndig_ff != 3'h0) begin
                  ndig_ff <= ndig_ff + 3'h1;
                end
                mant_ff <= mant_ff * 20'h0000a + {16'h0000, dval};
                if (dot_ff) begin
                  dadj_ff <= dadj_ff - 8'sh01;
                end
              end else if (!dot_ff) begin
                dadj_ff <= dadj_ff + 8'sh01;
              end
            end else if (chr == `ATF_CH_DOT && !dot_ff && !exp_seen_ff) begin
              dot_ff <= 1'b1;
            end else if (is_sign && pos_ff == 5'h00) begin
              neg_ff <= (chr == `ATF_CH_MINUS);
            end else begin
              err_ff <= 1'b1;
            end
          end
        end
        S_NORM: begin
          m_ff <= {mant_ff, {`ATF_MANT_SHIFT{1'b0}}};
          be_ff <= `ATF_BE_INIT;
          e10_ff <= e10_sum;
          st_ff <= (err_ff || mant_ff == 20'h00000) ? S_PACK : S_SCALE;
        end
        S_SCALE: begin
          if (!m_ff[31]) begin
            m_ff <= {m_ff[30:0], 1'b0};
            be_ff <= be_ff - 12'sh001;
          end else if (e10_ff > 9'sh000) begin
            e10_ff <= e10_ff - 9'sh001;
            if (mul10[35]) begin
              m_ff <= mul10[35:4];
              be_ff <= be_ff + 12'sh004;
            end else begin
              m_ff <= mul10[34:3];
              be_ff <= be_ff + 12'sh003;
            end
          end else if (e10_ff < 9'sh000) begin
            e10_ff <= e10_ff + 9'sh001;
            if (div10[32]) begin
              m_ff <= div10[32:1];
              be_ff <= be_ff - 12'sh003;
            end else begin
              m_ff <= div10[31:0];
              be_ff <= be_ff - 12'sh004;
            end
          end else begin
            st_ff <= S_PACK;
          end
        end
        S_PACK: begin
          // Single-precision assembly, underflow flushes to zero
          if (err_ff || mant_ff == 20'h00000 || biased <= 12'sh000) begin
            res_ff <= 32'h00000000;
          end else if (biased >= `ATF_FLT_INF) begin
            err_ff <= 1'b1;
          end else begin
            res_ff <= {neg_ff, biased[7:0],
              m_ff[`ATF_FRAC_HI:`ATF_FRAC_LO]};
          end
          st_ff <= S_WR_LO;
        end
        S_WR_LO: begin
          if (err_ff) begin
            st_ff <= S_FIN;
          end else begin
            mem_addr_ff <= dst_ff;
            mem_wdata_ff <= res_ff[15:0];
            mem_wr_ff <= 1'b1;
            st_ff <= S_WR_HI;
          end
        end
        S_WR_HI: begin
          mem_addr_ff <= dst_ff + 16'h0001;
          mem_wdata_ff <= res_ff[31:16];
          mem_wr_ff <= 1'b1;
          st_ff <= S_FIN;
        end
        S_FIN: begin
          conversion_error_flag_ff <= err_ff;
          zero_result_flag_ff <= !err_ff &&
            (res_ff[30:0] == 31'h0);
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          st_ff <= S_IDLE;
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* sim/atf_mem_model.sv */
`timescale 1ns/1ps
module atf_mem_model (
  input wire ref_clk,
  input wire [15:0] mem_addr_ff,
  input wire mem_rd_ff,
  input wire mem_wr_ff,
  input wire [15:0] mem_wdata_ff,
  output logic [15:0] mem_rdata = 16'h0000
);
  logic [15:0] mem [0:63];
  // Read data valid one cycle after the strobe, scrambled otherwise
  always @(posedge ref_clk) begin
    mem_rdata <= mem_rd_ff ? mem[mem_addr_ff[5:0]] : ~mem_rdata;
    if (mem_wr_ff) begin
      mem[mem_addr_ff[5:0]] <= mem_wdata_ff;
    end
  end
endmodule

/* sim/atf_convert_properties.sv */
`timescale 1ns/1ps
module atf_convert_properties (
  input wire ref_clk,
  input wire rst,
  input wire ascii_to_float_convert,
  input wire [15:0] dst_addr,
  input wire [15:0] mem_addr_ff,
  input wire mem_rd_ff,
  input wire mem_wr_ff,
  input wire [15:0] mem_wdata_ff,
  input wire busy_ff,
  input wire done_ff,
  input wire conversion_error_flag_ff,
  input wire zero_result_flag_ff
);
  logic [15:0] dst_ff;
  logic [15:0] lo_ff;
  logic [15:0] hi_ff;
  logic [4:0] nrd_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Capture of the conversion in flight
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dst_ff <= 16'h0000;
      lo_ff <= 16'h0000;
      hi_ff <= 16'h0000;
      nrd_ff <= 5'h00;
    end else begin
      if (ascii_to_float_convert && !busy_ff) begin
        dst_ff <= dst_addr;
        nrd_ff <= 5'h00;
      end else if (mem_rd_ff) begin
        nrd_ff <= nrd_ff + 5'h01;
      end
      if (mem_wr_ff && mem_addr_ff == dst_ff) begin
        lo_ff <= mem_wdata_ff;
      end
      if (mem_wr_ff && mem_addr_ff != dst_ff) begin
        hi_ff <= mem_wdata_ff;
      end
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_low_word_addr: assert property (
    $rose(mem_wr_ff) |-> mem_addr_ff == dst_ff) else $error("bad low addr");
  a_high_word_next: assert property (
    $rose(mem_wr_ff) |=> mem_wr_ff && mem_addr_ff == dst_ff + 16'h0001)
    else $error("high half not next");
  a_done_written: assert property (
    done_ff |-> $past(mem_wr_ff) == !conversion_error_flag_ff)
    else $error("write and error disagree");
  a_zero_flag_value: assert property (
    done_ff && !conversion_error_flag_ff |->
      zero_result_flag_ff == ({hi_ff[14:0], lo_ff} == 31'h0))
    else $error("zero flag wrong");
  a_err_no_zero: assert property (
    done_ff && conversion_error_flag_ff |-> !zero_result_flag_ff)
    else $error("zero flag with error");
  a_inf_error: assert property (
    done_ff && !conversion_error_flag_ff |-> hi_ff[14:7] != 8'hff)
    else $error("infinity without error");
  a_flags_hold: assert property (
    !done_ff |-> $stable({conversion_error_flag_ff, zero_result_flag_ff}))
    else $error("flags moved outside done");
  a_read_bound: assert property (
    mem_rd_ff |-> nrd_ff < 5'h0d) else $error("too many reads");
  a_busy_ends_done: assert property (
    $fell(busy_ff) == done_ff) else $error("busy and done disagree");
  a_start_taken: assert property (
    ascii_to_float_convert && !busy_ff |=> busy_ff)
    else $error("start not taken");
  c_error: cover property (done_ff && conversion_error_flag_ff);
  c_zero: cover property (done_ff && zero_result_flag_ff);
  c_write: cover property ($rose(mem_wr_ff));
endmodule

/* sim/ascii_text_to_float_converter_tb.sv */
`timescale 1ns/1ps
`define CHK(n, a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("ERROR %s exp %h got %h", n, b, a); \
  end \
end
module ascii_text_to_float_converter_tb;
  localparam logic [31:0] no_wr = 32'hdeaddead;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [15:0] src_addr = 16'h0000;
  logic [15:0] dst_addr = 16'h0020;
  wire [15:0] mem_rdata, mem_addr_ff, mem_wdata_ff;
  wire mem_rd_ff, mem_wr_ff, busy_ff, done_ff, err_ff, zero_ff;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] r;
  logic [31:0] lf = 32'h79eedd00;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  atf_convert i_dut (.ref_clk(ref_clk), .rst(rst),
    .ascii_to_float_convert(start), .src_addr(src_addr),
    .dst_addr(dst_addr), .mem_rdata(mem_rdata), .mem_addr_ff(mem_addr_ff),
    .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
    .mem_wdata_ff(mem_wdata_ff), .busy_ff(busy_ff), .done_ff(done_ff),
    .conversion_error_flag_ff(err_ff), .zero_result_flag_ff(zero_ff));
  atf_mem_model i_mem (.ref_clk(ref_clk), .mem_addr_ff(mem_addr_ff),
    .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata));
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Load text, note expectation, start; a second start while busy is ignored
  task automatic run(input string s, input logic [33:0] x);
    int i;
    @(posedge ref_clk);
    #1;
    lf = lfsr(lf);
    dst_addr = {12'h002, lf[3:0]};
    for (i = 0; i < 16; i++) i_mem.mem[i] = 16'h3131;
    i_mem.mem[dst_addr[5:0]] = no_wr[15:0];
    i_mem.mem[dst_addr[5:0] + 6'h01] = no_wr[31:16];
    for (i = 0; i <= s.len(); i++) begin
      if (i[0]) i_mem.mem[i / 2][7:0] = s[i];
      else i_mem.mem[i / 2][15:8] = s[i];
    end
    exp_q.push_back(x);
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    src_addr = 16'h0010;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    src_addr = 16'h0000;
    while (done_ff !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  always @(posedge ref_clk) begin
    #2;
    if (done_ff === 1'b1) begin
      e = exp_q.pop_front();
      r = {i_mem.mem[dst_addr[5:0] + 6'h01], i_mem.mem[dst_addr[5:0]]};
      `CHK("error flag", err_ff, e[33])
      `CHK("zero flag", zero_ff, e[32])
      `CHK("result", r, e[31:0])
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc >= 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    run("1.5", {2'b00, 32'h3fc00000});
    run("1A", {2'b10, no_wr});
    run("-2", {2'b00, 32'hc0000000});
    run("1E2", {2'b10, no_wr});
    run("1.0E+2", {2'b00, 32'h42c80000});
    run("1E+1E+1", {2'b10, no_wr});
    run("0.0", {2'b01, 32'h00000000});
    run("9E+99", {2'b10, no_wr});
    run("", {2'b10, no_wr});
    run("1234567", {2'b00, 32'h4996b400});
    run("1111111111111111111111111111", {2'b10, no_wr});
    run("+001.25", {2'b00, 32'h3fa00000});
    run("2.5E-1", {2'b00, 32'h3e800000});
    @(posedge ref_clk);
    #3;
    test_done();
  end
endmodule
bind atf_convert atf_convert_properties i_chk (.ref_clk(ref_clk), .rst(rst),
  .ascii_to_float_convert(ascii_to_float_convert), .dst_addr(dst_addr),
  .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
  .mem_wdata_ff(mem_wdata_ff), .busy_ff(busy_ff), .done_ff(done_ff),
  .conversion_error_flag_ff(conversion_error_flag_ff),
  .zero_result_flag_ff(zero_result_flag_ff));
